// ---- core/twst_pkg.sv ----
// shared constants and types for the two-wire slave transmitter
package twst_pkg;
  // register indices on the plain port
  localparam logic [1:0] ADDR_OWN    = 2'h0;
  localparam logic [1:0] ADDR_CTRL   = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [1:0] ADDR_DATA   = 2'h3;
  // control_reg bit positions
  localparam int CB_INT   = 7;
  localparam int CB_ACK   = 6;
  localparam int CB_BEGIN = 5;
  localparam int CB_HALT  = 4;
  localparam int CB_WCOL  = 3;
  localparam int CB_UEN   = 2;
  localparam int CB_IRQ   = 0;
  // own_address_reg field
  localparam int OB_GCE   = 0;
  // status codes
  localparam logic [7:0] SC_OWN_READ  = 8'hA8;
  localparam logic [7:0] SC_ARB_READ  = 8'hB0;
  localparam logic [7:0] SC_DATA_ACK  = 8'hB8;
  localparam logic [7:0] SC_DATA_NACK = 8'hC0;
  localparam logic [7:0] SC_LAST_ACK  = 8'hC8;
  localparam logic [7:0] SC_NO_INFO   = 8'hF8;
  localparam logic [7:0] SC_BUS_ERR   = 8'h00;
  // broadcast address and reset values
  localparam logic [6:0] BCAST_ADDR   = 7'h00;
  localparam logic [7:0] OWN_RESET    = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'hFF;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef struct packed {
    logic ackEn;
    logic beginReq;
    logic haltReq;
    logic unitEn;
    logic irqEn;
  } twst_ctrl_t;

  typedef enum logic [2:0] {
    IDLE, ADDR_SHIFT, ADDR_ACK, HOLD, TX_BITS, TX_ACK, IGNORE, BUS_ERR
  } twst_state_t;
endpackage : twst_pkg

// ---- core/twst_slave_tx.sv ----
// two-wire slave transmitter with register port and open-drain pins
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module twst_slave_tx
  import twst_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [1:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // two-wire pins, open drain
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe_n,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe_n,
  // neighbouring units
  input  wire logic       masterArbLost,
  input  wire logic       sleepActive,
  output logic            wakeRequest,
  output logic            startIssue
);

  twst_ctrl_t  ctrl;
  twst_state_t state;
  logic [7:0] ownAddr;
  logic [7:0] dataReg;
  logic [7:0] statusCode;
  logic [7:0] shiftReg;
  logic [3:0] bitCnt;
  logic       intFlag;
  logic       wcol;
  logic       sdaLow;
  logic       ackSeen;
  logic       startPend;
  logic       busBusy;
  logic       sclMeta, sclSync, sclPrev;
  logic       sdaMeta, sdaSync, sdaPrev;
  logic       sclRise, sclFall, startCond, stopCond;
  logic       ctrlWr, dataWr, intClr;
  logic       setInt;
  logic [7:0] next_code;
  logic       addrMatch;
  logic       frameErr;
  logic       leavingLast;
  logic       sclHoldTail;
  logic       sclHold;
  logic       wakeSet;

  // two flops before any logic looks at the pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
    end else begin
      sclMeta <= sclIn;
      sclSync <= sclMeta;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclSync;
      sdaPrev <= sdaSync;
    end
  end

  assign sclRise   = sclSync & ~sclPrev;
  assign sclFall   = ~sclSync & sclPrev;
  assign startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
  assign stopCond  = sclSync & sclPrev & ~sdaPrev & sdaSync;

  assign ctrlWr = regWr && (regAddr == ADDR_CTRL);
  assign dataWr = regWr && (regAddr == ADDR_DATA);
  assign intClr = ctrlWr && regWdata[CB_INT] && intFlag;
  assign leavingLast = (statusCode == SC_DATA_NACK) || (statusCode == SC_LAST_ACK);

  // ack_enable gates every recognition; bus is still watched
  assign addrMatch = ctrl.ackEn && ctrl.unitEn &&
                     ((shiftReg[7:1] == ownAddr[7:1]) ||
                      (ownAddr[OB_GCE] && (shiftReg[7:1] == BCAST_ADDR)));

  // START or STOP inside a byte or an acknowledge slot
  assign frameErr = (startCond || stopCond) &&
                    ((state == ADDR_ACK) || (state == TX_BITS) || (state == TX_ACK) ||
                     ((state == ADDR_SHIFT) && (bitCnt != 4'h0)));

  // bus counts as taken from START to STOP; a pending START waits on it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busBusy <= 1'b0;
    end else if (startCond) begin
      busBusy <= 1'b1;
    end else if (stopCond) begin
      busBusy <= 1'b0;
    end
  end

  // bus-side state machine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state      <= IDLE;
      bitCnt     <= 4'h0;
      shiftReg   <= 8'h00;
      sdaLow     <= 1'b0;
      ackSeen    <= 1'b0;
      setInt     <= 1'b0;
      next_code  <= SC_NO_INFO;
    end else begin
      setInt <= 1'b0;
      if (!ctrl.unitEn) begin
        state  <= IDLE;
        sdaLow <= 1'b0;
      end else if (frameErr) begin
        state     <= BUS_ERR;
        sdaLow    <= 1'b0;
        setInt    <= 1'b1;
        next_code <= SC_BUS_ERR;
      end else if (startCond && (state != HOLD) && (state != BUS_ERR)) begin
        state  <= ADDR_SHIFT;
        bitCnt <= 4'h0;
        sdaLow <= 1'b0;
      end else if (stopCond && (state != HOLD) && (state != BUS_ERR)) begin
        state  <= IDLE;
        sdaLow <= 1'b0;
      end else begin
        case (state)
          IDLE: begin
            sdaLow <= 1'b0;
          end
          ADDR_SHIFT: begin
            // sampling on SCL only, so this works with the core asleep
            if (sclRise && (bitCnt != BITS_PER_BYTE)) begin
              shiftReg <= {shiftReg[6:0], sdaSync};
              bitCnt   <= bitCnt + 4'h1;
            end else if (sclFall && (bitCnt == BITS_PER_BYTE)) begin
              if (addrMatch && shiftReg[0]) begin
                sdaLow    <= 1'b1;
                state     <= ADDR_ACK;
                next_code <= masterArbLost ? SC_ARB_READ : SC_OWN_READ;
              end else begin
                // write direction belongs to the receive side
                state <= IGNORE;
              end
            end
          end
          ADDR_ACK: begin
            if (sclFall) begin
              sdaLow <= 1'b0;
              state  <= HOLD;
              setInt <= 1'b1;
            end
          end
          HOLD: begin
            // byte is taken only after software has cleared the flag
            // SCL is still held here, so the first bit never races a rise
            if (!intFlag && !setInt) begin
              shiftReg <= dataReg;
              sdaLow   <= ~dataReg[7];
              bitCnt   <= 4'h1;
              state    <= TX_BITS;
            end
          end
          TX_BITS: begin
            if (sclFall) begin
              if (bitCnt == BITS_PER_BYTE) begin
                sdaLow <= 1'b0;
                state  <= TX_ACK;
              end else begin
                sdaLow   <= ~shiftReg[6];
                shiftReg <= {shiftReg[6:0], 1'b0};
                bitCnt   <= bitCnt + 4'h1;
              end
            end
          end
          TX_ACK: begin
            if (sclRise) begin
              ackSeen <= ~sdaSync;
            end else if (sclFall) begin
              setInt <= 1'b1;
              if (!ackSeen) begin
                next_code <= SC_DATA_NACK;
                state     <= IGNORE;
              end else if (!ctrl.ackEn) begin
                // ack_enable dropped: this was the final byte
                next_code <= SC_LAST_ACK;
                state     <= IGNORE;
              end else begin
                next_code <= SC_DATA_ACK;
                state     <= HOLD;
              end
            end
          end
          IGNORE: begin
            sdaLow <= 1'b0;
          end
          BUS_ERR: begin
            sdaLow <= 1'b0;
            if (!intFlag && !setInt) begin
              state <= IDLE;
            end
          end
          default: begin
            state <= IDLE;
          end
        endcase
      end
    end
  end

  // status latched together with the flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      statusCode <= SC_NO_INFO;
    end else if (setInt) begin
      statusCode <= next_code;
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      intFlag <= 1'b0;
    end else if (setInt) begin
      intFlag <= 1'b1;
    end else if (intClr) begin
      intFlag <= 1'b0;
    end
  end

  // control_reg fields; halt self-clears on error recovery
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else if (ctrlWr) begin
      ctrl.ackEn    <= regWdata[CB_ACK];
      ctrl.beginReq <= regWdata[CB_BEGIN];
      ctrl.unitEn   <= regWdata[CB_UEN];
      ctrl.irqEn    <= regWdata[CB_IRQ];
      ctrl.haltReq  <= regWdata[CB_HALT] &&
                       !(intClr && (statusCode == SC_BUS_ERR));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ownAddr <= OWN_RESET;
    end else if (regWr && (regAddr == ADDR_OWN)) begin
      ownAddr <= regWdata;
    end
  end

  // data_reg only changes by software, never from the bus
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dataReg <= DATA_RESET;
    end else if (dataWr && intFlag) begin
      dataReg <= regWdata;
    end
  end

  // a data write while the flag is clear is refused and flagged
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wcol <= 1'b0;
    end else if (dataWr) begin
      wcol <= ~intFlag;
    end
  end

  // START request held until the bus goes free
  // the master unit makes the START itself; this only asks for it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      startPend  <= 1'b0;
      startIssue <= 1'b0;
    end else begin
      startIssue <= 1'b0;
      if (intClr && leavingLast && regWdata[CB_BEGIN]) begin
        startPend <= 1'b1;
      end else if (startPend && !busBusy) begin
        startPend  <= 1'b0;
        startIssue <= 1'b1;
      end
    end
  end

  // wake raised by a match while asleep, dropped when flag clears
  assign wakeSet = (state == ADDR_ACK) && sclFall && sleepActive;

  // flag rises two cycles after the match; a bare flag test drops wake at once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wakeRequest <= 1'b0;
    end else if (wakeSet) begin
      wakeRequest <= 1'b1;
    end else if (!intFlag && !setInt) begin
      wakeRequest <= 1'b0;
    end
  end

  // SCL stays low one cycle past the hold so the first bit is on SDA before the rise
  // costs one cycle of bus time per byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclHoldTail <= 1'b0;
    end else begin
      sclHoldTail <= (state == HOLD);
    end
  end

  // register reads answer one cycle later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      if (regAddr == ADDR_OWN) begin
        regRdata <= ownAddr;
      end else if (regAddr == ADDR_CTRL) begin
        regRdata <= {intFlag, ctrl.ackEn, ctrl.beginReq, ctrl.haltReq,
                     wcol, ctrl.unitEn, 1'b0, ctrl.irqEn};
      end else if (regAddr == ADDR_STATUS) begin
        regRdata <= intFlag ? statusCode : SC_NO_INFO;
      end else begin
        regRdata <= dataReg;
      end
    end else begin
      regRdata <= 8'h00;
    end
  end

  // pins only ever pull low; enable low means driving
  assign sdaOut  = 1'b0;
  assign sclOut  = 1'b0;
  assign sdaOe_n = ~sdaLow;
  // stretching also covers a long wake-up, which blocks the bus meanwhile
  assign sclHold = (state == HOLD) || sclHoldTail;
  assign sclOe_n = ~sclHold;

endmodule : twst_slave_tx

// ---- verif/twst_slave_tx_props.sv ----
// port assertions for the two-wire slave transmitter
`timescale 1ns/10ps
module twst_slave_tx_props (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // register port
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  // pins
  input wire logic       sclIn,
  input wire logic       sclOut,
  input wire logic       sclOe_n,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe_n,
  // neighbours
  input wire logic       masterArbLost,
  input wire logic       sleepActive,
  input wire logic       wakeRequest,
  input wire logic       startIssue
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // software needs a few cycles to react, so a stretch never ends at once
  sequence sHeld;
    !sclOe_n [*4];
  endsequence
  sequence sWoke;
    $rose(wakeRequest);
  endsequence
  a_reset_lines_free: assert property ($rose(rst_n) |-> sclOe_n && sdaOe_n && !startIssue)
    else $error("lines not free after reset");
  a_rdata_idle: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data outside its cycle");
  a_pins_pull_only: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
    else $error("pin driven high");
  a_start_one_cycle: assert property (startIssue |=> !startIssue)
    else $error("start pulse too long");
  a_start_bus_free: assert property (startIssue |-> sclOe_n && sdaOe_n)
    else $error("start while holding bus");
  a_wake_in_sleep: assert property (sWoke |-> sleepActive)
    else $error("wake outside sleep");
  a_wake_holds_scl: assert property (sWoke |-> ##[0:16] !sclOe_n)
    else $error("no clock hold after wake");
  a_stretch_held: assert property ($fell(sclOe_n) |-> sHeld)
    else $error("stretch released early");
  a_sda_scl_low: assert property ($changed(sdaOe_n) |-> !sclIn)
    else $error("data moved while clock high");
endmodule : twst_slave_tx_props
bind twst_slave_tx twst_slave_tx_props twst_slave_tx_props_i (
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .sclIn(sclIn), .sclOut(sclOut), .sclOe_n(sclOe_n),
  .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .masterArbLost(masterArbLost),
  .sleepActive(sleepActive), .wakeRequest(wakeRequest), .startIssue(startIssue)
);

// ---- verif/twst_master_model.sv ----
// behavioural master receiver on the two-wire bus
`timescale 1ns/10ps
module twst_master_model (
  // bus wires and own open-drain drives, 1 = released
  input  wire logic scl,
  input  wire logic sda,
  output logic      sclDrv,
  output logic      sdaDrv
);
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end
  // long low phase keeps slave data moves clear of the rise
  task automatic slot(input logic b, output logic s);
    sdaDrv = b;
    #500;
    sclDrv = 1'b1;
    while (scl !== 1'b1) #100;
    #150;
    s = sda;
    #150;
    sclDrv = 1'b0;
  endtask : slot
  task automatic start();
    // bus moves stay clear of the bench clock edges
    #20;
    sdaDrv = 1'b1;
    sclDrv = 1'b1;
    #400;
    sdaDrv = 1'b0;
    #400;
    sclDrv = 1'b0;
  endtask : start
  task automatic stop();
    #100;
    sdaDrv = 1'b0;
    #150;
    sclDrv = 1'b1;
    #400;
    sdaDrv = 1'b1;
    #400;
  endtask : stop
  task automatic byteOut(input logic [7:0] d, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) slot(d[i], s);
    slot(1'b1, a);
  endtask : byteOut
  // a = 0 asks for more, a = 1 ends the read
  task automatic byteIn(input logic a, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
    slot(a, s);
  endtask : byteIn
endmodule : twst_master_model

// ---- verif/twst_slave_tx_bench.sv ----
// self-checking bench for the two-wire slave transmitter
`timescale 1ns/10ps
module twst_slave_tx_bench;
  import twst_pkg::*;
  logic       clk, rst_n, regWr, regRd, sclOut, sclOe_n, sdaOut, sdaOe_n;
  logic       sclDrv, sdaDrv, scl, sda, arbLost, sleep, wake, startIssue, rdSeen, errBit;
  logic [1:0] regAddr;
  logic [7:0] regWdata, regRdata, dat[3];
  logic [7:0] q[$];
  int         miscompares, check_count, seed;
  // per test: address byte, lost arbitration, ack on, bytes, last answer, asleep
  logic [7:0] rAdr[6] = '{8'hA5, 8'h01, 8'hA4, 8'hA7, 8'hA5, 8'hA5};
  logic       rArb[6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  logic       rAck[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  int         rN[6] = '{3, 2, 0, 0, 0, 1};
  logic       rLast[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic       rSlp[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  assign scl = sclDrv & (sclOe_n | sclOut);
  assign sda = sdaDrv & (sdaOe_n | sdaOut);
  twst_slave_tx twst_slave_tx_i (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sclIn(scl),
    .sclOut(sclOut), .sclOe_n(sclOe_n), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .masterArbLost(arbLost), .sleepActive(sleep), .wakeRequest(wake),
    .startIssue(startIssue));
  twst_master_model twst_master_model_i (.scl(scl), .sda(sda), .sclDrv(sclDrv),
    .sdaDrv(sdaDrv));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic tally(input logic ok, input string what);
    check_count++;
    if (!ok) begin
      miscompares++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : tally
  task automatic cmpReg(input logic [7:0] got, input logic [7:0] exp);
    tally(got === exp, "register read");
  endtask : cmpReg
  task automatic cmpBus(input logic [7:0] got, input logic [7:0] exp);
    tally(got === exp, "bus or pin value");
  endtask : cmpBus
  always @(posedge clk) begin
    if (rdSeen === 1'b1) cmpReg(regRdata, q.pop_front());
    rdSeen <= regRd;
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    q.push_back(e);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
  endtask : rd
  // sel 0 watches the clock hold, sel 1 the start pulse
  task automatic waitLvl(input int sel, input logic v);
    int n;
    n = 0;
    while ((sel == 0 ? sclOe_n : startIssue) !== v && n < 600) begin
      @(posedge clk);
      n++;
    end
    tally(n < 600, "wait ran out");
  endtask : waitLvl
  task automatic master(input int r);
    logic       a;
    logic [7:0] d;
    twst_master_model_i.start();
    twst_master_model_i.byteOut(rAdr[r], a);
    cmpBus(8'(a), rN[r] != 0 ? 8'h00 : 8'h01);
    for (int i = 0; i < rN[r]; i++) begin
      twst_master_model_i.byteIn(i == rN[r] - 1 ? rLast[r] : 1'b0, d);
      cmpBus(d, dat[i]);
    end
    if (rN[r] != 0 && !rLast[r]) begin
      twst_master_model_i.byteIn(1'b1, d);
      cmpBus(d, 8'hFF);
    end
    twst_master_model_i.stop();
  endtask : master
  task automatic software(input int r);
    for (int i = 0; i < rN[r]; i++) begin
      waitLvl(0, 1'b1);
      waitLvl(0, 1'b0);
      if (i == 0) rd(ADDR_STATUS, rArb[r] ? SC_ARB_READ : SC_OWN_READ);
      else rd(ADDR_STATUS, SC_DATA_ACK);
      if (i == 0 && rSlp[r]) cmpBus(8'(wake), 8'h01);
      wr(ADDR_DATA, dat[i]);
      wr(ADDR_CTRL, {1'b1, i < rN[r] - 1, 6'b000100});
    end
    repeat (3) @(posedge clk);
    cmpBus(8'(wake), 8'h00);
  endtask : software
  initial begin
    #3000000;
    miscompares++;
    end_sim();
  end
  initial begin
    seed = 8622;
    miscompares = 0;
    check_count = 0;
    {rst_n, regWr, regRd, arbLost, sleep, rdSeen, regAddr, regWdata} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_OWN, OWN_RESET);
    rd(ADDR_STATUS, SC_NO_INFO);
    rd(ADDR_DATA, DATA_RESET);
    wr(ADDR_DATA, 8'h5A);
    rd(ADDR_CTRL, 8'h08);
    rd(ADDR_DATA, DATA_RESET);
    wr(ADDR_OWN, 8'hA5);
    rd(ADDR_OWN, 8'hA5);
    $display("test registers done");
    for (int r = 0; r < 6; r++) begin
      arbLost <= rArb[r];
      sleep   <= rSlp[r];
      wr(ADDR_CTRL, {1'b0, rAck[r], 6'b000100});
      for (int i = 0; i < 3; i++) dat[i] = 8'($random(seed));
      fork
        master(r);
        software(r);
      join
      if (rN[r] != 0) begin
        rd(ADDR_STATUS, rLast[r] ? SC_DATA_NACK : SC_LAST_ACK);
        wr(ADDR_CTRL, 8'hE4);
        waitLvl(1, 1'b1);
      end
      rd(ADDR_STATUS, SC_NO_INFO);
      $display("test %0d done", r);
    end
    // STOP after two address bits is an illegal frame position
    twst_master_model_i.start();
    twst_master_model_i.slot(1'b1, errBit);
    twst_master_model_i.slot(1'b0, errBit);
    twst_master_model_i.stop();
    rd(ADDR_STATUS, SC_BUS_ERR);
    wr(ADDR_CTRL, 8'h94);
    rd(ADDR_CTRL, 8'h04);
    rd(ADDR_STATUS, SC_NO_INFO);
    $display("test bus error done");
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule : twst_slave_tx_bench
